/* File: verilog/ckg_map.vh */
// Register map, field positions, reset values and timing constants of the clock bank
`ifndef CKG_MAP_VH
`define CKG_MAP_VH

// Byte addresses of the bank
`define CKG_ADDR_FIRST   8'h19
`define CKG_ADDR_CP      8'h19
`define CKG_ADDR_REFDIV  8'h1a
`define CKG_ADDR_OUTDIV  8'h1b
`define CKG_ADDR_PLLOP   8'h1c
`define CKG_ADDR_OUTEN   8'h1d
`define CKG_ADDR_PINROLE 8'h1e
`define CKG_ADDR_LOOP    8'h1f
`define CKG_ADDR_WDOG    8'h20
`define CKG_NUM_REGS     8

// Reset values
`define CKG_RST_CP       8'h14
`define CKG_RST_REFDIV   8'h19
`define CKG_RST_OUTDIV   8'h43
`define CKG_RST_PLLOP    8'h3f
`define CKG_RST_OUTEN    8'h33
`define CKG_RST_PINROLE  8'h90
`define CKG_RST_LOOP     8'h84
`define CKG_RST_WDOG     8'h80

// Writable bit masks; clear bits are reserved or read-only
`define CKG_WMASK_FULL   8'hff
`define CKG_WMASK_PINROLE 8'he3
`define CKG_WMASK_LOOP   8'h0e
`define CKG_WMASK_WDOG   8'h1e

// Field positions
`define CKG_CP_FIRST      1
`define CKG_CP_BIAS       0
`define CKG_RD_DOUBLER    7
`define CKG_RD_BYP1       6
`define CKG_RD_BYP2       5
`define CKG_RD_DIV_HI     4
`define CKG_OD_THIRD_LO   4
`define CKG_PO_HIRES      7
`define CKG_PO_REFSRC     6
`define CKG_PO_PLL3_RUN   5
`define CKG_PO_PLL3_LOCK  4
`define CKG_PO_PLL2_RUN   3
`define CKG_PO_PLL2_LOCK  2
`define CKG_PO_PLL1_RUN   1
`define CKG_PO_PLL1_LOCK  0
`define CKG_OE_DIFFA_GATE 7
`define CKG_OE_DIFFB_GATE 6
`define CKG_OE_DIFFA_EN   5
`define CKG_OE_DIFFB_EN   4
`define CKG_OE_DIV4_SRC   3
`define CKG_OE_SLEW       2
`define CKG_PR_SEA_EN     7
`define CKG_PR_ROLE_HI    6
`define CKG_PR_ROLE_LO    5
`define CKG_LP_ORDER      3
`define CKG_LP_CH2_EN     2
`define CKG_LP_POLE       1
`define CKG_WD_FSW_EN     4
`define CKG_WATCHDOG_EN         3
`define CKG_WD_SEL_HI     2
`define CKG_WD_SEL_LO     1
`define CKG_WD_ALARM      0

// Enable pin roles
`define CKG_ROLE_OE       2'b00
`define CKG_ROLE_PD       2'b01
`define CKG_ROLE_PSAVE    2'b10
`define CKG_ROLE_FSEL     2'b11

// Watchdog timeouts in milliseconds and clock rate in kHz
`define CKG_CLK_KHZ       25000
`define CKG_WD_T0_MS      250
`define CKG_WD_T1_MS      500
`define CKG_WD_T2_MS      2000
`define CKG_WD_T3_MS      4000

`endif

/* File: verilog/ckg_wdog.v */
// Watchdog timer with selectable timeout and sticky alarm
`timescale 1ns/100ps
module ckg_wdog
#(
  parameter CW     = 32,
  parameter T0_CYC = 6250000,
  parameter T1_CYC = 12500000,
  parameter T2_CYC = 50000000,
  parameter T3_CYC = 100000000
)
(
  input  wire       mclk_i,
  input  wire       arst_n_i,
  input  wire       en_i,
  input  wire [1:0] sel_i,
  input  wire       kick_i,
  input  wire       restart_i,
  output reg        alarm_o
);

  reg  [CW-1:0] cnt_q;
  reg  [CW-1:0] limit;
  wire          expire;

  // Timeout in cycles for the selected period
  always @*
  begin
    case (sel_i)
      2'b00:   limit = T0_CYC[CW-1:0];
      2'b01:   limit = T1_CYC[CW-1:0];
      2'b10:   limit = T2_CYC[CW-1:0];
      default: limit = T3_CYC[CW-1:0];
    endcase
  end

  assign expire = en_i && (cnt_q >= limit - {{(CW-1){1'b0}}, 1'b1});

  // Counter restarts on service so a busy host never alarms
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      cnt_q <= {CW{1'b0}};
    else if (!en_i || kick_i || restart_i || expire)
      cnt_q <= {CW{1'b0}};
    else
      cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
  end

  // Sticky alarm; a timeout in the clearing cycle still sets it
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      alarm_o <= 1'b0;
    else if (expire)
      alarm_o <= 1'b1;
    else if (!en_i || restart_i)
      alarm_o <= 1'b0;
  end

endmodule

/* File: verilog/ckg_regs.v */
// Second PLL, output enable and watchdog configuration bytes 19h to 20h
`timescale 1ns/100ps
`include "ckg_map.vh"
module ckg_regs
#(
  parameter WD_T0_CYC = `CKG_WD_T0_MS * `CKG_CLK_KHZ,
  parameter WD_T1_CYC = `CKG_WD_T1_MS * `CKG_CLK_KHZ,
  parameter WD_T2_CYC = `CKG_WD_T2_MS * `CKG_CLK_KHZ,
  parameter WD_T3_CYC = `CKG_WD_T3_MS * `CKG_CLK_KHZ
)
(
  input  wire       mclk_i,
  input  wire       arst_n_i,
  input  wire [7:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  output reg  [7:0] reg_rdata_o,
  output reg        reg_rvalid_o,
  input  wire       second_enable_input_i,
  input  wire       enable_pin_i,
  output wire [6:0] pump_scale_o,
  output wire       pump_bias_current_sel_o,
  output wire       ref_freq_doubler_en_o,
  output wire       ref_bypass_div_one_o,
  output wire       ref_bypass_div_two_o,
  output wire [4:0] ref_divider_value_o,
  output wire [3:0] third_out_divider_o,
  output wire [3:0] fourth_out_divider_o,
  output wire       spread_hires_en_o,
  output wire       second_pll_ref_source_o,
  output wire       first_pll_run_o,
  output wire       first_pll_lock_keep_o,
  output wire       second_pll_run_o,
  output wire       second_pll_lock_keep_o,
  output wire       third_pll_run_o,
  output wire       third_pll_lock_keep_o,
  output wire       diff_a_pin_gated_o,
  output wire       diff_b_pin_gated_o,
  output wire       diff_a_out_en_o,
  output wire       diff_b_out_en_o,
  output wire       fourth_divider_source_o,
  output wire       single_a_slew_strong_o,
  output wire [1:0] bank_supply_level_o,
  output wire       single_a_out_en_o,
  output wire [1:0] enable_pin_role_o,
  output wire [1:0] freq_set_soft_select_o,
  output wire       loop_order_sel_o,
  output wire       second_pll_chan_two_en_o,
  output wire       loop_extra_pole_en_o,
  output wire       freq_switch_en_o,
  output wire       watchdog_en_o,
  output wire [1:0] watchdog_sel_o,
  output wire       watchdog_alarm_o,
  output reg        diff_a_active_o,
  output reg        diff_b_active_o,
  output reg        single_a_active_o,
  output reg        power_down_low_o,
  output reg        single_a_power_saving_o,
  output reg  [1:0] freq_set_o
);

  reg  [7:0] regs_q [0:`CKG_NUM_REGS-1];
  reg  [2:0] oe2_sync_q;
  reg  [2:0] pin_sync_q;
  reg        oe2_lvl_q;
  reg        pin_lvl_q;
  wire [7:0] idx;
  wire       hit;
  wire       alarm;
  integer    i;

  // Reset value of a bank byte by index
  function [7:0] rst_val;
    input integer k;
    begin
      case (k)
        0:       rst_val = `CKG_RST_CP;
        1:       rst_val = `CKG_RST_REFDIV;
        2:       rst_val = `CKG_RST_OUTDIV;
        3:       rst_val = `CKG_RST_PLLOP;
        4:       rst_val = `CKG_RST_OUTEN;
        5:       rst_val = `CKG_RST_PINROLE;
        6:       rst_val = `CKG_RST_LOOP;
        default: rst_val = `CKG_RST_WDOG;
      endcase
    end
  endfunction

  // Writable bits of a bank byte by index
  function [7:0] wr_mask;
    input integer k;
    begin
      case (k)
        5:       wr_mask = `CKG_WMASK_PINROLE;
        6:       wr_mask = `CKG_WMASK_LOOP;
        7:       wr_mask = `CKG_WMASK_WDOG;
        default: wr_mask = `CKG_WMASK_FULL;
      endcase
    end
  endfunction

  // Address decode over the byte window
  assign idx = reg_addr_i - `CKG_ADDR_FIRST;
  assign hit = (reg_addr_i >= `CKG_ADDR_FIRST) && (reg_addr_i <= `CKG_ADDR_WDOG);

  // Register storage; reserved and read-only bits are forced to reset value
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      for (i = 0; i < `CKG_NUM_REGS; i = i + 1)
        regs_q[i] <= rst_val(i);
    end
    else if (reg_wr_i && hit)
    begin
      for (i = 0; i < `CKG_NUM_REGS; i = i + 1)
        if (idx == i[7:0])
          regs_q[i] <= (reg_wdata_i & wr_mask(i)) | (rst_val(i) & ~wr_mask(i));
    end
  end

  // Read answer one cycle after the strobe; unmapped bytes read zero
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      reg_rdata_o  <= 8'h00;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i && hit && idx == `CKG_NUM_REGS - 1)
        reg_rdata_o <= {regs_q[7][7:1], alarm};
      else if (reg_rd_i && hit)
        reg_rdata_o <= regs_q[idx[2:0]];
      else if (reg_rd_i)
        reg_rdata_o <= 8'h00;
    end
  end

  // Charge pump, reference divider and output divider fields
  assign pump_scale_o            = regs_q[0][7:`CKG_CP_FIRST];
  assign pump_bias_current_sel_o = regs_q[0][`CKG_CP_BIAS];
  assign ref_freq_doubler_en_o   = regs_q[1][`CKG_RD_DOUBLER];
  assign ref_bypass_div_one_o    = regs_q[1][`CKG_RD_BYP1];
  assign ref_bypass_div_two_o    = regs_q[1][`CKG_RD_BYP2];
  // Divide range is the host's duty; the field stores what is written
  assign ref_divider_value_o     = regs_q[1][`CKG_RD_DIV_HI:0];
  assign third_out_divider_o     = regs_q[2][7:`CKG_OD_THIRD_LO];
  assign fourth_out_divider_o    = regs_q[2][`CKG_OD_THIRD_LO-1:0];

  // PLL operation fields
  assign spread_hires_en_o       = regs_q[3][`CKG_PO_HIRES];
  assign second_pll_ref_source_o = regs_q[3][`CKG_PO_REFSRC];
  assign third_pll_run_o         = regs_q[3][`CKG_PO_PLL3_RUN];
  assign third_pll_lock_keep_o   = regs_q[3][`CKG_PO_PLL3_LOCK];
  assign second_pll_run_o        = regs_q[3][`CKG_PO_PLL2_RUN];
  assign second_pll_lock_keep_o  = regs_q[3][`CKG_PO_PLL2_LOCK];
  assign first_pll_run_o         = regs_q[3][`CKG_PO_PLL1_RUN];
  assign first_pll_lock_keep_o   = regs_q[3][`CKG_PO_PLL1_LOCK];

  // Output control fields
  assign diff_a_pin_gated_o      = regs_q[4][`CKG_OE_DIFFA_GATE];
  assign diff_b_pin_gated_o      = regs_q[4][`CKG_OE_DIFFB_GATE];
  assign diff_a_out_en_o         = regs_q[4][`CKG_OE_DIFFA_EN];
  assign diff_b_out_en_o         = regs_q[4][`CKG_OE_DIFFB_EN];
  assign fourth_divider_source_o = regs_q[4][`CKG_OE_DIV4_SRC];
  assign single_a_slew_strong_o  = regs_q[4][`CKG_OE_SLEW];
  assign bank_supply_level_o     = regs_q[4][`CKG_OE_SLEW-1:0];

  // Pin role and frequency set fields
  assign single_a_out_en_o       = regs_q[5][`CKG_PR_SEA_EN];
  assign enable_pin_role_o       = regs_q[5][`CKG_PR_ROLE_HI:`CKG_PR_ROLE_LO];
  assign freq_set_soft_select_o  = regs_q[5][1:0];

  // Loop and watchdog fields
  assign loop_order_sel_o         = regs_q[6][`CKG_LP_ORDER];
  assign second_pll_chan_two_en_o = regs_q[6][`CKG_LP_CH2_EN];
  assign loop_extra_pole_en_o     = regs_q[6][`CKG_LP_POLE];
  assign freq_switch_en_o         = regs_q[7][`CKG_WD_FSW_EN];
  assign watchdog_en_o            = regs_q[7][`CKG_WATCHDOG_EN];
  assign watchdog_sel_o           = regs_q[7][`CKG_WD_SEL_HI:`CKG_WD_SEL_LO];
  assign watchdog_alarm_o         = alarm;

  // Pin synchronisers; a level is taken only when stages two and three agree
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      oe2_sync_q <= 3'h0;
      pin_sync_q <= 3'h0;
      oe2_lvl_q  <= 1'b0;
      pin_lvl_q  <= 1'b0;
    end
    else
    begin
      oe2_sync_q <= {oe2_sync_q[1:0], second_enable_input_i};
      pin_sync_q <= {pin_sync_q[1:0], enable_pin_i};
      if (oe2_sync_q[1] == oe2_sync_q[2])
        oe2_lvl_q <= oe2_sync_q[2];
      if (pin_sync_q[1] == pin_sync_q[2])
        pin_lvl_q <= pin_sync_q[2];
    end
  end

  // Effective output controls; a gated output also needs the second enable pin
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      diff_a_active_o         <= 1'b0;
      diff_b_active_o         <= 1'b0;
      single_a_active_o       <= 1'b0;
      power_down_low_o        <= 1'b1;
      single_a_power_saving_o <= 1'b0;
      freq_set_o              <= 2'b00;
    end
    else
    begin
      diff_a_active_o <= diff_a_out_en_o & (~diff_a_pin_gated_o | oe2_lvl_q);
      diff_b_active_o <= diff_b_out_en_o & (~diff_b_pin_gated_o | oe2_lvl_q);
      single_a_active_o       <= single_a_out_en_o;
      power_down_low_o        <= 1'b1;
      single_a_power_saving_o <= 1'b0;
      case (enable_pin_role_o)
        `CKG_ROLE_OE:    single_a_active_o <= single_a_out_en_o & pin_lvl_q;
        `CKG_ROLE_PD:    power_down_low_o <= pin_lvl_q;
        `CKG_ROLE_PSAVE: single_a_power_saving_o <= ~pin_lvl_q;
        default:         power_down_low_o <= 1'b1;
      endcase
      // Switching off holds set zero; pin role select overrides the low bit
      if (!freq_switch_en_o)
        freq_set_o <= 2'b00;
      else if (enable_pin_role_o == `CKG_ROLE_FSEL)
        freq_set_o <= {freq_set_soft_select_o[1], pin_lvl_q};
      else
        freq_set_o <= freq_set_soft_select_o;
    end
  end

  // Any bank access services the watchdog; writing byte 20h restarts it
  ckg_wdog
  #(
    .CW     (32),
    .T0_CYC (WD_T0_CYC),
    .T1_CYC (WD_T1_CYC),
    .T2_CYC (WD_T2_CYC),
    .T3_CYC (WD_T3_CYC)
  )
  u_wdog
  (
    .mclk_i    (mclk_i),
    .arst_n_i  (arst_n_i),
    .en_i      (watchdog_en_o),
    .sel_i     (watchdog_sel_o),
    .kick_i    ((reg_wr_i | reg_rd_i) & hit),
    .restart_i (reg_wr_i && reg_addr_i == `CKG_ADDR_WDOG),
    .alarm_o   (alarm)
  );

endmodule

/* File: verif/ckg_regs_chk.sv */
// Checker of bus timing, field updates and watchdog timing of the bank
`timescale 1ns/100ps
module ckg_regs_chk
#(
  parameter WD_T0_CYC = 20,
  parameter WD_T1_CYC = 40,
  parameter WD_T2_CYC = 80,
  parameter WD_T3_CYC = 160
)
(
  input wire       mclk_i,
  input wire       arst_n_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire       reg_wr_i,
  input wire       reg_rd_i,
  input wire [7:0] reg_rdata_o,
  input wire       reg_rvalid_o,
  input wire       second_enable_input_i,
  input wire       enable_pin_i,
  input wire [6:0] pump_scale_o,
  input wire       diff_a_out_en_o,
  input wire       diff_a_pin_gated_o,
  input wire       diff_a_active_o,
  input wire [1:0] enable_pin_role_o,
  input wire       power_down_low_o,
  input wire       freq_switch_en_o,
  input wire [1:0] freq_set_o,
  input wire       watchdog_en_o,
  input wire [1:0] watchdog_sel_o,
  input wire       watchdog_alarm_o
);
  reg  [31:0] quiet_q;
  wire [31:0] tsel_w;
  wire        hit_w;
  // Bank accesses service the watchdog, so quiet time restarts on each one
  assign hit_w  = (reg_wr_i | reg_rd_i) & (reg_addr_i >= 8'h19) & (reg_addr_i <= 8'h20);
  assign tsel_w = watchdog_sel_o[1] ? (watchdog_sel_o[0] ? WD_T3_CYC : WD_T2_CYC)
                                    : (watchdog_sel_o[0] ? WD_T1_CYC : WD_T0_CYC);
  // Quiet cycle counter while the watchdog runs
  always @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      quiet_q <= 32'h0;
    else if (hit_w | !watchdog_en_o)
      quiet_q <= 32'h0;
    else
      quiet_q <= quiet_q + 32'h1;
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  // Pin levels must settle through the synchroniser before outputs follow
  sequence s_gate_low;
    (diff_a_out_en_o && diff_a_pin_gated_o && !second_enable_input_i) [*6];
  endsequence
  sequence s_pd_low;
    (enable_pin_role_o == 2'b01 && !enable_pin_i) [*6];
  endsequence
  AST_RVALID: assert property (reg_rvalid_o == $past(reg_rd_i))
    else $error("read valid not one cycle after strobe");
  AST_PUMP: assert property (reg_wr_i && reg_addr_i == 8'h19 |=>
    {pump_scale_o, 1'b0} == ($past(reg_wdata_i) & 8'hfe)) else $error("pump scale not stored");
  AST_RD_ALARM: assert property (reg_rd_i && reg_addr_i == 8'h20 |=>
    reg_rdata_o[0] == $past(watchdog_alarm_o)) else $error("alarm bit misread");
  AST_RD_RSVD: assert property (reg_rd_i && reg_addr_i == 8'h1f |=>
    (reg_rdata_o & 8'hf1) == 8'h80) else $error("reserved bits misread");
  AST_GATE: assert property (s_gate_low |=> !diff_a_active_o)
    else $error("gated output stays active");
  AST_PD_ROLE: assert property (s_pd_low |=> !power_down_low_o)
    else $error("power down role not followed");
  AST_FSW_OFF: assert property (!freq_switch_en_o [*3] |=> freq_set_o == 2'b00)
    else $error("frequency set moves while switching off");
  AST_WD_LATE: assert property (watchdog_en_o && quiet_q == tsel_w + 32'h1 |->
    watchdog_alarm_o) else $error("alarm late");
  AST_WD_EARLY: assert property ($rose(watchdog_alarm_o) |-> quiet_q + 32'h2 >= tsel_w)
    else $error("alarm early");
endmodule
bind ckg_regs ckg_regs_chk #(.WD_T0_CYC(WD_T0_CYC), .WD_T1_CYC(WD_T1_CYC),
  .WD_T2_CYC(WD_T2_CYC), .WD_T3_CYC(WD_T3_CYC)) u_chk (.mclk_i(mclk_i),
  .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .reg_rvalid_o(reg_rvalid_o), .second_enable_input_i(second_enable_input_i),
  .enable_pin_i(enable_pin_i), .pump_scale_o(pump_scale_o),
  .diff_a_out_en_o(diff_a_out_en_o), .diff_a_pin_gated_o(diff_a_pin_gated_o),
  .diff_a_active_o(diff_a_active_o), .enable_pin_role_o(enable_pin_role_o),
  .power_down_low_o(power_down_low_o), .freq_switch_en_o(freq_switch_en_o),
  .freq_set_o(freq_set_o), .watchdog_en_o(watchdog_en_o),
  .watchdog_sel_o(watchdog_sel_o), .watchdog_alarm_o(watchdog_alarm_o));

/* File: verif/ckg_host.sv */
// Byte-wide host model standing in for the serial engine
`timescale 1ns/100ps
module ckg_host
(
  input  wire       mclk_i,
  input  wire [7:0] rdata_i,
  input  wire       rvalid_i,
  output reg  [7:0] addr_o,
  output reg  [7:0] wdata_o,
  output reg        wr_o,
  output reg        rd_o
);
  // Idle bus from time zero
  initial
  begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // Reserved bits always go out at their reset levels
  function [7:0] fix_rsvd(input [7:0] a, input [7:0] d);
    case (a)
      8'h1e: fix_rsvd = (d & 8'he3) | 8'h10;
      8'h1f: fix_rsvd = (d & 8'h0e) | 8'h80;
      8'h20: fix_rsvd = (d & 8'h1f) | 8'h80;
      default: fix_rsvd = d;
    endcase
  endfunction
  // One strobe edge per byte; the next call waits an edge before raising it again
  task wr_byte(input [7:0] a, input [7:0] d);
  begin
    @(posedge mclk_i);
    addr_o <= a;
    wdata_o <= fix_rsvd(a, d);
    wr_o <= 1'b1;
    @(posedge mclk_i);
    wr_o <= 1'b0;
  end
  endtask
  // Read strobe for one edge, then a bounded wait for the valid pulse
  task rd_byte(input [7:0] a, output [7:0] d, output ok);
    integer n;
  begin
    ok = 1'b0;
    d = 8'h00;
    @(posedge mclk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge mclk_i);
    rd_o <= 1'b0;
    for (n = 0; n < 3 && !ok; n = n + 1)
    begin
      @(posedge mclk_i);
      if (rvalid_i === 1'b1)
      begin
        ok = 1'b1;
        d = rdata_i;
      end
    end
  end
  endtask
endmodule

/* File: verif/ckg_regs_tb_top.sv */
// Self-checking bench of the clock configuration bank
`timescale 1ns/100ps
module ckg_regs_tb_top;
  localparam [63:0] RSTV = 64'h808490333f431914;
  localparam [63:0] WM   = 64'h1e0ee3ffffffffff;
  reg         mclk_i = 1'b0;
  reg         arst_n_i = 1'b0;
  reg         sec_en = 1'b0;
  reg         pin = 1'b1;
  reg  [31:0] rs = 32'h0001747b;
  reg  [63:0] ex = RSTV;
  reg  [7:0]  rd_v;
  reg         ok;
  integer     errors = 0;
  integer     cmp_count = 0;
  integer     i, j, k;
  wire [63:0] fv;
  wire [7:0]  addr, wdata, rdata;
  wire [2:0]  pins;
  wire [1:0]  fset;
  wire        wr, rd, rvalid;
  wire [1:0]  act;
  // Reserved bits have no field port; tie them to their reset levels
  assign fv[44:42] = 3'b100;
  assign fv[48]    = 1'b0;
  assign fv[55:52] = 4'h8;
  assign fv[63:61] = 3'b100;
  always #20 mclk_i = ~mclk_i;
  ckg_host u_host (.mclk_i(mclk_i), .rdata_i(rdata), .rvalid_i(rvalid), .addr_o(addr),
    .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  // Field outputs gathered back into byte order for whole-byte compares
  ckg_regs #(.WD_T0_CYC(20), .WD_T1_CYC(40), .WD_T2_CYC(80), .WD_T3_CYC(160)) u_dut (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .second_enable_input_i(sec_en), .enable_pin_i(pin), .pump_scale_o(fv[7:1]),
    .pump_bias_current_sel_o(fv[0]), .ref_freq_doubler_en_o(fv[15]),
    .ref_bypass_div_one_o(fv[14]), .ref_bypass_div_two_o(fv[13]),
    .ref_divider_value_o(fv[12:8]), .third_out_divider_o(fv[23:20]),
    .fourth_out_divider_o(fv[19:16]), .spread_hires_en_o(fv[31]),
    .second_pll_ref_source_o(fv[30]), .third_pll_run_o(fv[29]),
    .third_pll_lock_keep_o(fv[28]), .second_pll_run_o(fv[27]),
    .second_pll_lock_keep_o(fv[26]), .first_pll_run_o(fv[25]),
    .first_pll_lock_keep_o(fv[24]), .diff_a_pin_gated_o(fv[39]),
    .diff_b_pin_gated_o(fv[38]), .diff_a_out_en_o(fv[37]), .diff_b_out_en_o(fv[36]),
    .fourth_divider_source_o(fv[35]), .single_a_slew_strong_o(fv[34]),
    .bank_supply_level_o(fv[33:32]), .single_a_out_en_o(fv[47]),
    .enable_pin_role_o(fv[46:45]), .freq_set_soft_select_o(fv[41:40]),
    .loop_order_sel_o(fv[51]), .second_pll_chan_two_en_o(fv[50]),
    .loop_extra_pole_en_o(fv[49]), .freq_switch_en_o(fv[60]), .watchdog_en_o(fv[59]),
    .watchdog_sel_o(fv[58:57]), .watchdog_alarm_o(fv[56]), .diff_a_active_o(act[1]),
    .diff_b_active_o(act[0]), .single_a_active_o(pins[2]), .power_down_low_o(pins[1]),
    .single_a_power_saving_o(pins[0]), .freq_set_o(fset));
  function [31:0] xs(input [31:0] x);
    reg [31:0] y;
  begin
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    xs = y ^ (y << 5);
  end
  endfunction
  // Pin held low per role: {single active, power-down low, power saving}
  function [2:0] pin_low(input [1:0] r);
    pin_low = (r == 2'b00) ? 3'b010 : (r == 2'b01) ? 3'b100 : (r == 2'b10) ? 3'b111 : 3'b110;
  endfunction
  task print_verdict;
  begin
    if (errors == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask
  task chk(input string nm, input [7:0] e, input [7:0] s);
  begin
    cmp_count = cmp_count + 1;
    if (e !== s)
    begin
      errors = errors + 1;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  end
  endtask
  task rchk(input [7:0] a, input [7:0] e);
  begin
    u_host.rd_byte(a, rd_v, ok);
    if (!ok)
    begin
      errors = errors + 1;
      print_verdict;
    end
    else
      chk("rdata", e, rd_v);
  end
  endtask
  // Write through the host and keep the expected image; outside bytes are dropped
  task wrm(input [7:0] a, input [7:0] d);
  begin
    u_host.wr_byte(a, d);
    k = a - 8'h19;
    if (a >= 8'h19 && a <= 8'h20)
      ex[8*k +: 8] = (ex[8*k +: 8] & ~WM[8*k +: 8]) | (d & WM[8*k +: 8]);
  end
  endtask
  initial
  begin
    #2000000;
    errors = errors + 1;
    print_verdict;
  end
  initial
  begin
    repeat (5) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    for (i = 0; i < 8; i = i + 1)
      rchk(8'h19 + i[7:0], RSTV[8*i +: 8]);
    // Random traffic with the watchdog kept off; unmapped bytes mixed in
    for (i = 0; i < 150; i = i + 1)
    begin
      rs = xs(rs);
      sec_en <= rs[8];
      pin <= rs[9];
      wrm(8'h19 + {5'h0, rs[2:0]}, rs[31:24] & ((rs[2:0] == 3'h7) ? 8'hf7 : 8'hff));
      rchk(8'h19 + {5'h0, rs[5:3]}, ex[{rs[5:3], 3'b000} +: 8]);
      if (rs[12])
        wrm(8'h21 + {4'h0, rs[16:13]}, rs[23:16]);
      for (j = 0; j < 8; j = j + 1)
        chk("fields", ex[8*j +: 8] & WM[8*j +: 8], fv[8*j +: 8] & WM[8*j +: 8]);
    end
    rchk(8'h40, 8'h00);
    arst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    ex = RSTV;
    rchk(8'h1d, 8'h33);
    chk("diff act", 8'h03, {6'h0, act});
    // Both differentials gated by the second enable pin, pin low then high
    wrm(8'h1d, 8'hf3);
    sec_en <= 1'b0;
    repeat (6) @(posedge mclk_i);
    chk("diff act", 8'h00, {6'h0, act});
    sec_en <= 1'b1;
    repeat (6) @(posedge mclk_i);
    chk("diff act", 8'h03, {6'h0, act});
    pin <= 1'b0;
    for (i = 0; i < 4; i = i + 1)
    begin
      wrm(8'h1e, {1'b1, i[1:0], 5'h00});
      repeat (6) @(posedge mclk_i);
      chk("pins", {5'h0, pin_low(i[1:0])}, {5'h0, pins});
    end
    wrm(8'h20, 8'h10);
    for (i = 0; i < 4; i = i + 1)
    begin
      wrm(8'h1e, {6'h20, i[1:0]});
      repeat (3) @(posedge mclk_i);
      chk("freq set", {6'h0, i[1:0]}, {6'h0, fset});
    end
    // Pin role select replaces the low bit of the set with the low pin
    wrm(8'h1e, 8'he3);
    repeat (3) @(posedge mclk_i);
    chk("freq set", 8'h02, {6'h0, fset});
    // Each timeout code: quiet until just before, alarm just after, then disable
    for (i = 0; i < 4; i = i + 1)
    begin
      wrm(8'h20, {4'h0, 1'b1, i[1:0], 1'b0});
      repeat ((20 << i) - 3) @(posedge mclk_i);
      chk("alarm", 8'h00, {7'h0, fv[56]});
      repeat (5) @(posedge mclk_i);
      chk("alarm", 8'h01, {7'h0, fv[56]});
      rchk(8'h20, {4'h8, 1'b1, i[1:0], 1'b1});
      wrm(8'h20, 8'h01);
      rchk(8'h20, 8'h80);
    end
    print_verdict;
  end
endmodule
